// file: bench/cpu_instruction_timing_decode_tb.sv
/*
 cpu_instruction_timing_decode_tb: table-driven check of decode fields and cycle counts.
 Assumes the program memory model feeds the block and the monitor is bound to it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
   begin \
      n_compared++; \
      if ((act) !== (exp)) begin \
         fail_count++; \
         $display("[ERR] t=%0t act=%h exp=%h", $time, (act), (exp)); \
      end \
   end
module cpu_instruction_timing_decode_tb;
   typedef struct {logic [13:0] w; logic sk; logic [1:0] pm; logic [1:0] g; logic [2:0] k; logic [6:0] f;
      logic d; logic [2:0] b; logic s; logic [1:0] m; logic ind; logic [3:0] cyc;} row_t;
   localparam int nr = 21;
   // word, skip, pointer-in-program-memory, group, class, file, dest, bit, pointer, mode, indirect, cycles
   row_t rows [nr] = '{
      '{14'h07a5, 1'h0, 2'h0, 2'h0, 3'h0, 7'h25, 1'h1, 3'h7, 1'h1, 2'h1, 1'h0, 4'h1},
      '{14'h077f, 1'h0, 2'h0, 2'h0, 3'h0, 7'h7f, 1'h0, 3'h6, 1'h1, 2'h3, 1'h0, 4'h1},
      '{14'h0780, 1'h0, 2'h1, 2'h0, 3'h0, 7'h00, 1'h1, 3'h7, 1'h0, 2'h0, 1'h1, 4'h2},
      '{14'h0781, 1'h0, 2'h1, 2'h0, 3'h0, 7'h01, 1'h1, 3'h7, 1'h1, 2'h1, 1'h1, 4'h1},
      '{14'h1690, 1'h0, 2'h0, 2'h1, 3'h0, 7'h10, 1'h1, 3'h5, 1'h0, 2'h0, 1'h0, 4'h1},
      '{14'h187f, 1'h1, 2'h0, 2'h1, 3'h4, 7'h7f, 1'h1, 3'h0, 1'h1, 2'h3, 1'h0, 4'h2},
      '{14'h1fa0, 1'h0, 2'h0, 2'h1, 3'h4, 7'h20, 1'h1, 3'h7, 1'h0, 2'h0, 1'h0, 4'h1},
      '{14'h0bb0, 1'h1, 2'h0, 2'h0, 3'h4, 7'h30, 1'h1, 3'h7, 1'h0, 2'h0, 1'h0, 4'h2},
      '{14'h0f31, 1'h0, 2'h0, 2'h0, 3'h4, 7'h31, 1'h0, 3'h6, 1'h1, 2'h1, 1'h0, 4'h1},
      '{14'h0b80, 1'h1, 2'h1, 2'h0, 3'h4, 7'h00, 1'h1, 3'h7, 1'h0, 2'h0, 1'h1, 4'h3},
      '{14'h2123, 1'h0, 2'h0, 2'h2, 3'h1, 7'h23, 1'h0, 3'h2, 1'h1, 2'h3, 1'h0, 4'h2},
      '{14'h2845, 1'h0, 2'h0, 2'h2, 3'h3, 7'h45, 1'h0, 3'h0, 1'h1, 2'h1, 1'h0, 4'h2},
      '{14'h32a6, 1'h0, 2'h0, 2'h2, 3'h3, 7'h26, 1'h0, 3'h5, 1'h0, 2'h2, 1'h0, 4'h2},
      '{14'h345a, 1'h0, 2'h0, 2'h2, 3'h2, 7'h5a, 1'h0, 3'h0, 1'h0, 2'h2, 1'h0, 4'h2},
      '{14'h0008, 1'h0, 2'h0, 2'h2, 3'h2, 7'h08, 1'h0, 3'h0, 1'h0, 2'h0, 1'h0, 4'h2},
      '{14'h0009, 1'h0, 2'h0, 2'h2, 3'h2, 7'h09, 1'h0, 3'h0, 1'h1, 2'h1, 1'h0, 4'h2},
      '{14'h000a, 1'h0, 2'h0, 2'h2, 3'h1, 7'h0a, 1'h0, 3'h0, 1'h0, 2'h2, 1'h0, 4'h2},
      '{14'h000b, 1'h0, 2'h0, 2'h2, 3'h3, 7'h0b, 1'h0, 3'h0, 1'h1, 2'h3, 1'h0, 4'h2},
      '{14'h0016, 1'h0, 2'h2, 2'h2, 3'h0, 7'h16, 1'h0, 3'h0, 1'h1, 2'h2, 1'h1, 4'h2},
      '{14'h3f15, 1'h0, 2'h2, 2'h2, 3'h0, 7'h15, 1'h0, 3'h6, 1'h0, 2'h1, 1'h1, 4'h1},
      '{14'h0103, 1'h0, 2'h0, 2'h0, 3'h0, 7'h03, 1'h0, 3'h2, 1'h1, 2'h3, 1'h0, 4'h1}};
   logic clk_i, rst_n_i, instr_valid_i, skip_cond_i;
   logic [13:0] instr_i;
   logic [1:0] ptr_in_progmem_i, q_phase_o, ptr_mode_o;
   logic cycle_end_o, fetch_o, discard_o, busy_o, extra_cycle_o, dest_file_o, ptr_sel_o, indirect_o;
   logic rmw_read_o, rmw_write_file_o, rmw_write_accum_o;
   instr_decode_pkg::group_t group_o;
   instr_decode_pkg::class_t kind_o;
   logic [6:0] file_addr_o;
   logic [2:0] bit_pos_o;
   int fail_count, n_compared, ticks, n, i;
   cpu_instruction_timing_decode dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
      .instr_valid_i(instr_valid_i), .ptr_in_progmem_i(ptr_in_progmem_i), .skip_cond_i(skip_cond_i),
      .q_phase_o(q_phase_o), .cycle_end_o(cycle_end_o), .fetch_o(fetch_o), .discard_o(discard_o),
      .busy_o(busy_o), .extra_cycle_o(extra_cycle_o), .group_o(group_o), .kind_o(kind_o),
      .file_addr_o(file_addr_o), .dest_file_o(dest_file_o), .bit_pos_o(bit_pos_o), .ptr_sel_o(ptr_sel_o),
      .ptr_mode_o(ptr_mode_o), .indirect_o(indirect_o), .rmw_read_o(rmw_read_o),
      .rmw_write_file_o(rmw_write_file_o), .rmw_write_accum_o(rmw_write_accum_o));
   prog_mem_model mem_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .fetch_i(fetch_o), .count_i(6'(nr)),
      .instr_o(instr_i), .valid_o(instr_valid_i));
   always #4 clk_i = ~clk_i;
   // a hang is cut off well beyond the 140 or so clocks the table needs
   always @(posedge clk_i) begin
      ticks++;
      if (ticks == 3000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // counts clocks until the next take, polling just after each edge
   task automatic wait_fetch(output int cnt);
      cnt = 0;
      while (fetch_o !== 1'b1 && cnt < 40) begin
         @(posedge clk_i);
         #1;
         cnt++;
      end
   endtask
   initial begin
      clk_i = 1'b0;
      rst_n_i = 1'b0;
      skip_cond_i = 1'b0;
      ptr_in_progmem_i = 2'h0;
      for (i = 0; i < nr; i++) mem_u.mem[i] = rows[i].w;
      repeat (10) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      wait_fetch(n);
      // table: fields just after each take, then clocks until the following take
      for (i = 0; i < nr; i++) begin
         @(posedge clk_i);
         #1;
         skip_cond_i = rows[i].sk;
         ptr_in_progmem_i = rows[i].pm;
         `CHK(group_o, rows[i].g)
         `CHK(kind_o, rows[i].k)
         `CHK(file_addr_o, rows[i].f)
         if (rows[i].g != 2'h2) `CHK(dest_file_o, rows[i].d)
         `CHK(bit_pos_o, rows[i].b)
         `CHK(ptr_sel_o, rows[i].s)
         `CHK(ptr_mode_o, rows[i].m)
         `CHK(indirect_o, rows[i].ind)
         `CHK(busy_o, 1'b1)
         if (i < nr - 1) begin
            wait_fetch(n);
            `CHK(n, 4 * rows[i].cyc - 1)
         end
         $display("row %0d done", i);
      end
      // program exhausted: no take and nothing held
      repeat (8) @(posedge clk_i);
      #1;
      `CHK(busy_o | fetch_o, 1'b0)
      $display("idle test done");
      // reset once while idle and once in mid-instruction; the program restarts each time
      ptr_in_progmem_i = 2'h0;
      for (i = 0; i < 2; i++) begin
         rst_n_i = 1'b0;
         repeat (2) @(posedge clk_i);
         #1;
         `CHK(q_phase_o, 2'h0)
         `CHK(busy_o | fetch_o | rmw_read_o, 1'b0)
         `CHK(kind_o, instr_decode_pkg::cls_plain)
         rst_n_i = 1'b1;
         wait_fetch(n);
         @(posedge clk_i);
         #1;
         `CHK(file_addr_o, rows[0].f)
         @(posedge clk_i);
         #1;
         $display("reset test %0d done", i);
      end
      tally_and_finish();
   end
endmodule
bind cpu_instruction_timing_decode timing_decode_monitor mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .instr_valid_i(instr_valid_i), .ptr_in_progmem_i(ptr_in_progmem_i), .skip_cond_i(skip_cond_i),
   .q_phase_o(q_phase_o), .cycle_end_o(cycle_end_o), .fetch_o(fetch_o), .discard_o(discard_o),
   .busy_o(busy_o), .extra_cycle_o(extra_cycle_o), .group_o(group_o), .kind_o(kind_o), .file_addr_o(file_addr_o),
   .dest_file_o(dest_file_o), .bit_pos_o(bit_pos_o), .ptr_sel_o(ptr_sel_o), .ptr_mode_o(ptr_mode_o),
   .indirect_o(indirect_o), .rmw_read_o(rmw_read_o), .rmw_write_file_o(rmw_write_file_o),
   .rmw_write_accum_o(rmw_write_accum_o));
`undef CHK
`default_nettype wire

// file: bench/prog_mem_model.sv
/*
 prog_mem_model: program memory offering one 14-bit word at a time to the decode block.
 Assumes the bench loads mem and count_i before reset is released.
*/
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic fetch_i,
   input wire logic [5:0] count_i,
   output logic [13:0] instr_o,
   output logic valid_o
);
   logic [13:0] mem [0:31];
   logic [5:0] pc = 6'h00;
   logic noise = 1'b0;
   // address moves only on a take, so the offered word stands still in between
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pc <= 6'h00;
      end else if (fetch_i) begin
         pc <= pc + 6'h01;
      end
      noise <= ~noise;
   end
   // past the program end the lines churn, so a stray read cannot look like a valid word
   assign valid_o = (pc < count_i);
   assign instr_o = valid_o ? mem[pc[4:0]] : {7{noise, ~noise}};
endmodule
`default_nettype wire

// file: bench/timing_decode_monitor.sv
/*
 timing_decode_monitor: concurrent checks on the ports of the instruction timing and decode block.
 Assumes it is bound to the top module and that one clock with a synchronous active-low reset drives all.
*/
`timescale 1ns/1ps
`default_nettype none
module timing_decode_monitor (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic instr_valid_i,
   input wire logic [1:0] ptr_in_progmem_i,
   input wire logic skip_cond_i,
   input wire logic [1:0] q_phase_o,
   input wire logic cycle_end_o,
   input wire logic fetch_o,
   input wire logic discard_o,
   input wire logic busy_o,
   input wire logic extra_cycle_o,
   input wire instr_decode_pkg::group_t group_o,
   input wire instr_decode_pkg::class_t kind_o,
   input wire logic [6:0] file_addr_o,
   input wire logic dest_file_o,
   input wire logic [2:0] bit_pos_o,
   input wire logic ptr_sel_o,
   input wire logic [1:0] ptr_mode_o,
   input wire logic indirect_o,
   input wire logic rmw_read_o,
   input wire logic rmw_write_file_o,
   input wire logic rmw_write_accum_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // cycle timing: four clocks per instruction cycle, takes and drops only at its end
   a_quarter_rate: assert property (cycle_end_o |-> q_phase_o == 2'h3 ##1 !cycle_end_o [*3] ##1 cycle_end_o)
      else $error("instruction cycle is not four clocks");
   a_fetch_gate: assert property (fetch_o |-> cycle_end_o && instr_valid_i)
      else $error("word taken outside cycle end or while invalid");
   a_discard_gate: assert property (discard_o |-> cycle_end_o && !fetch_o)
      else $error("discard outside cycle end or together with a take");
   a_take_busy: assert property (fetch_o |=> busy_o)
      else $error("taken word not held");
   // operand fields may only move at a take; flush clears the class but not the operands
   a_fields_held: assert property (!fetch_o |=> $stable(file_addr_o) && $stable(bit_pos_o) && $stable(ptr_mode_o))
      else $error("operand fields changed without a take");
   a_flush_quiet: assert property (discard_o |=> (!busy_o && kind_o == instr_decode_pkg::cls_plain && !rmw_read_o && !rmw_write_file_o) [*4])
      else $error("flush cycle not idle");
   // read-modify-write: a file store always follows its read two clocks earlier
   a_rmw_order: assert property (rmw_write_file_o |-> $past(rmw_read_o, 2) && q_phase_o == 2'h3)
      else $error("file store without preceding read");
   a_dest_file: assert property (rmw_write_file_o |-> dest_file_o)
      else $error("file store with accumulator destination");
   a_dest_accum: assert property (rmw_write_accum_o |-> !dest_file_o)
      else $error("accumulator store with file destination");
   a_extra_cause: assert property ($rose(extra_cycle_o) |-> (indirect_o && ptr_in_progmem_i[ptr_sel_o] && extra_cycle_o) [*4] ##1 !extra_cycle_o)
      else $error("extra cycle without program memory pointer or wrong length");
   // cycle counts per class, judged from the first phase of the executing cycle; skips are judged at its last phase
   a_plain_one: assert property (busy_o && !extra_cycle_o && q_phase_o == 2'h0 && kind_o == instr_decode_pkg::cls_plain && !(indirect_o && ptr_in_progmem_i[ptr_sel_o]) |-> ##3 (fetch_o || !instr_valid_i) && !discard_o)
      else $error("plain instruction not single cycle");
   a_branch_two: assert property (busy_o && q_phase_o == 2'h0 && !indirect_o && kind_o inside {instr_decode_pkg::cls_call, instr_decode_pkg::cls_return, instr_decode_pkg::cls_jump} |-> ##3 discard_o)
      else $error("call, return or jump did not drop the prefetch");
   a_skip_taken: assert property (busy_o && cycle_end_o && !indirect_o && kind_o == instr_decode_pkg::cls_skip |-> discard_o == skip_cond_i)
      else $error("skip drop does not follow the condition");
   // the access cycle is the exec cycle, or the extra one when the pointer sits in program memory
   a_bit_reads: assert property (busy_o && q_phase_o == 2'h1 && group_o == instr_decode_pkg::grp_bit
      && (extra_cycle_o || !(indirect_o && ptr_in_progmem_i[ptr_sel_o])) |-> rmw_read_o)
      else $error("bit instruction did not read its file register");
   a_byte_store: assert property (busy_o && q_phase_o == 2'h3 && group_o == instr_decode_pkg::grp_byte
      && (extra_cycle_o || !(indirect_o && ptr_in_progmem_i[ptr_sel_o]))
      |-> (dest_file_o ? rmw_write_file_o : rmw_write_accum_o))
      else $error("byte result not stored to its destination");
   c_discard: cover property (discard_o);
   c_extra: cover property (extra_cycle_o);
   c_accum: cover property (rmw_write_accum_o);
endmodule
`default_nettype wire

// file: common/decode_if.sv
/*
 decode_if: carries one instruction word to the field decoder and its decoded fields back.
 Assumes the decoder is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
   logic [13:0] word;
   instr_decode_pkg::group_t group;
   instr_decode_pkg::class_t kind;
   logic [6:0] file_addr;
   logic dest_file;
   logic [2:0] bit_pos;
   logic ptr_sel;
   logic [1:0] ptr_mode;
   logic file_op;
   logic result_write;
   logic indirect;
   modport producer(input word, output group, output kind, output file_addr, output dest_file,
      output bit_pos, output ptr_sel, output ptr_mode, output file_op, output result_write,
      output indirect);
   modport consumer(output word, input group, input kind, input file_addr, input dest_file,
      input bit_pos, input ptr_sel, input ptr_mode, input file_op, input result_write,
      input indirect);
endinterface
`default_nettype wire

// file: common/instr_decode_pkg.sv
/*
 instr_decode_pkg: shared constants and types for the instruction timing and decode block.
 Assumes 14-bit instruction words and a clock that runs at the oscillator rate.
*/
package instr_decode_pkg;
   localparam int WORD_W = 14;
   localparam int FILE_W = 7;
   localparam int BITSEL_W = 3;
   // oscillator periods per instruction cycle, and phase positions inside one
   localparam int OSC_PER_INSTR = 4;
   localparam logic [1:0] PHASE_FIRST = 2'h0;
   localparam logic [1:0] PHASE_READ = 2'h1;
   localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_INSTR - 1);
   // field positions
   localparam int GRP_MSB = 13;
   localparam int GRP_LSB = 12;
   localparam int DEST_BIT = 7;
   localparam int F_MSB = 6;
   localparam int F_LSB = 0;
   localparam int B_MSB = 9;
   localparam int B_LSB = 7;
   localparam int BIT_TEST_BIT = 11;
   localparam int N_SHORT_BIT = 2;
   localparam int N_INDEX_BIT = 6;
   localparam int MM_MSB = 1;
   localparam int MM_LSB = 0;
   localparam logic [1:0] GRP_BYTE_CODE = 2'h0;
   localparam logic [1:0] GRP_BIT_CODE = 2'h1;
   // window registers sit at file addresses 0 and 1; the upper six bits are zero
   localparam logic [5:0] WINDOW_ADDR_HI = 6'h00;
   // mask and match pairs; masked-off bits are the don't-care positions
   localparam logic [13:0] M_CTRL = 14'h3f80, V_CTRL = 14'h0000;
   localparam logic [13:0] M_ZERO_ACC = 14'h3ffc, V_ZERO_ACC = 14'h0100;
   localparam logic [13:0] M_LONG = 14'h3800, V_CALL = 14'h2000, V_JUMP = 14'h2800;
   localparam logic [13:0] M_REL = 14'h3e00, V_REL = 14'h3200;
   localparam logic [13:0] M_RETLIT = 14'h3f00, V_RETLIT = 14'h3400;
   localparam logic [13:0] M_FULL = 14'h3fff;
   localparam logic [13:0] V_RET = 14'h0008, V_RETINT = 14'h0009;
   localparam logic [13:0] V_CALLACC = 14'h000a, V_JUMPACC = 14'h000b;
   localparam logic [13:0] M_PTR_SHORT = 14'h3ff0, V_PTR_SHORT = 14'h0010;
   localparam logic [13:0] M_PTR_INDEX = 14'h3f00, V_PTR_INDEX = 14'h3f00;
   localparam logic [13:0] M_SKIPF = 14'h3f00, V_DEC_SKIP = 14'h0b00, V_INC_SKIP = 14'h0f00;
   localparam logic [13:0] M_BTEST = 14'h3c00, V_SKIP_ZERO = 14'h1800, V_SKIP_ONE = 14'h1c00;

   typedef enum logic [1:0] {grp_byte, grp_bit, grp_literal} group_t;
   typedef enum logic [2:0] {cls_plain, cls_call, cls_return, cls_jump, cls_skip} class_t;
   typedef enum logic [1:0] {st_idle, st_exec, st_extra, st_flush} seq_state_t;
endpackage

// file: design/cpu_instruction_timing_decode.sv
/*
 cpu_instruction_timing_decode: decode and instruction-cycle sequencing for an 8-bit core.
 Assumes instr_i holds the prefetched word while fetch_o is low, and that skip_cond_i and
 ptr_in_progmem_i come from same-clock core logic; skip_cond_i is valid at the cycle's last phase, ptr_in_progmem_i from its read phase on.
*/
// Summary of operation
// RULE_01 - each instruction is one 14-bit word carrying opcode and operands
// RULE_02 - words sort into byte, bit, and literal/control format groups
// RULE_03 - instructions take one instruction cycle unless an exception applies
// RULE_04 - direct and accumulator-computed subroutine calls take two cycles
// RULE_05 - plain, literal and interrupt returns take two cycles
// RULE_06 - jumps of all kinds and taken skips take two cycles
// RULE_07 - indirect access with pointer in program memory adds one cycle
// RULE_08 - one instruction cycle is four oscillator clock periods
// RULE_09 - every file-naming instruction reads, modifies and stores the register; here bit tests only read and never store
// RULE_10 - destination bit 0 stores to accumulator, 1 stores to the file
// RULE_11 - file address field selects 0x00 to 0x7F of current data space
// RULE_12 - bit instructions carry a bit position within the 8-bit register
// RULE_13 - pointer number picks pointer pair 0 or 1
// RULE_14 - two-bit mode picks pre/post increment or decrement of the pointer
// RULE_15 - don't-care bits never affect execution
// RULE_16 - two-cycle instructions drop the prefetched word and idle one cycle; here the extra indirect cycle stalls fetch and keeps the word
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_timing_decode (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [13:0] instr_i,
   input wire logic instr_valid_i,
   input wire logic [1:0] ptr_in_progmem_i,
   input wire logic skip_cond_i,
   output logic [1:0] q_phase_o,
   output logic cycle_end_o,
   output logic fetch_o,
   output logic discard_o,
   output logic busy_o,
   output logic extra_cycle_o,
   output instr_decode_pkg::group_t group_o,
   output instr_decode_pkg::class_t kind_o,
   output logic [6:0] file_addr_o,
   output logic dest_file_o,
   output logic [2:0] bit_pos_o,
   output logic ptr_sel_o,
   output logic [1:0] ptr_mode_o,
   output logic indirect_o,
   output logic rmw_read_o,
   output logic rmw_write_file_o,
   output logic rmw_write_accum_o
);
   decode_if dec();
   instr_decode_pkg::seq_state_t state;
   instr_decode_pkg::seq_state_t next_state;
   logic [1:0] phase;
   logic cycle_end;
   logic held_file_op;
   logic held_result_write;

   instr_phase_counter u_phase (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .phase_o(phase),
      .cycle_end_o(cycle_end)
   );

   assign dec.word = instr_i;

   instr_field_decoder u_decode (
      .dec(dec)
   );

   // cycle-count decisions about the instruction being held
   wire two_cycle = (kind_o == instr_decode_pkg::cls_call) // [RULE_04]
      || (kind_o == instr_decode_pkg::cls_return) // [RULE_05]
      || (kind_o == instr_decode_pkg::cls_jump); // [RULE_06]
   // a skip only costs its second cycle when the condition says skip
   wire skip_taken = (kind_o == instr_decode_pkg::cls_skip) && skip_cond_i; // [RULE_06]
   wire need_flush = two_cycle || skip_taken;
   wire need_extra = indirect_o && ptr_in_progmem_i[ptr_sel_o]; // [RULE_07]
   wire in_exec = (state == instr_decode_pkg::st_exec);
   wire in_extra = (state == instr_decode_pkg::st_extra);
   wire holding = in_exec || in_extra;

   // sequencer: decides at the last phase of each instruction cycle
   always_comb begin
      next_state = state;
      case (state)
         instr_decode_pkg::st_exec: begin
            if (need_extra) begin
               next_state = instr_decode_pkg::st_extra; // [RULE_07]
            end else if (need_flush) begin
               next_state = instr_decode_pkg::st_flush; // [RULE_16]
            end else begin
               // plain instructions end after their single cycle
               next_state = instr_valid_i ? instr_decode_pkg::st_exec : // [RULE_03]
                  instr_decode_pkg::st_idle;
            end
         end
         instr_decode_pkg::st_extra: begin
            if (need_flush) begin
               next_state = instr_decode_pkg::st_flush;
            end else begin
               next_state = instr_valid_i ? instr_decode_pkg::st_exec : instr_decode_pkg::st_idle;
            end
         end
         instr_decode_pkg::st_idle, instr_decode_pkg::st_flush: begin
            next_state = instr_valid_i ? instr_decode_pkg::st_exec : instr_decode_pkg::st_idle;
         end
         default: begin
            next_state = instr_decode_pkg::st_idle;
         end
      endcase
   end

   // a new word is taken only when the sequencer goes back to execute from a finished cycle
   wire take_word = cycle_end && instr_valid_i && (next_state == instr_decode_pkg::st_exec);
   // the extra indirect cycle stalls fetch; the flush throws the prefetched word away
   wire drop_word = cycle_end && holding && (next_state == instr_decode_pkg::st_flush);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= instr_decode_pkg::st_idle;
      end else if (cycle_end) begin
         state <= next_state;
      end
   end

   // operand fields are captured with the word, so they stand for the whole instruction
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         group_o <= instr_decode_pkg::grp_literal;
         kind_o <= instr_decode_pkg::cls_plain;
         file_addr_o <= 7'h00;
         dest_file_o <= 1'b0;
         bit_pos_o <= 3'h0;
         ptr_sel_o <= 1'b0;
         ptr_mode_o <= 2'h0;
         indirect_o <= 1'b0;
         held_file_op <= 1'b0;
         held_result_write <= 1'b0;
      end else if (take_word) begin
         group_o <= dec.group; // [RULE_02]
         kind_o <= dec.kind;
         file_addr_o <= dec.file_addr; // [RULE_11]
         dest_file_o <= dec.dest_file; // [RULE_10]
         bit_pos_o <= dec.bit_pos; // [RULE_12]
         ptr_sel_o <= dec.ptr_sel; // [RULE_13]
         ptr_mode_o <= dec.ptr_mode; // [RULE_14]
         indirect_o <= dec.indirect;
         held_file_op <= dec.file_op;
         held_result_write <= dec.result_write;
      end else if (drop_word || (cycle_end && !take_word && !holding)) begin
         // nothing valid is held in a flush or idle cycle, so no stale access leaks out
         kind_o <= instr_decode_pkg::cls_plain;
         indirect_o <= 1'b0;
         held_file_op <= 1'b0;
         held_result_write <= 1'b0;
      end
   end

   // the data access happens in the last cycle that holds the instruction; with the extra
   // indirect cycle it moves there, which is what the pointer into program memory waits for
   wire access_cycle = (in_exec && !need_extra) || in_extra;
   wire last_phase = (phase == instr_decode_pkg::PHASE_LAST);
   // read always happens for a named register, even when the result only overwrites it
   assign rmw_read_o = access_cycle && held_file_op // [RULE_09]
      && (phase == instr_decode_pkg::PHASE_READ);
   assign rmw_write_file_o = access_cycle && held_result_write // [RULE_10]
      && dest_file_o && last_phase;
   assign rmw_write_accum_o = access_cycle && held_result_write // [RULE_10]
      && !dest_file_o && last_phase;

   // handshake strobes toward program memory
   assign fetch_o = take_word; // [RULE_16]
   assign discard_o = drop_word; // [RULE_16]
   assign q_phase_o = phase; // [RULE_08]
   assign cycle_end_o = cycle_end;
   assign busy_o = holding;
   assign extra_cycle_o = in_extra;
   // don't-care bits can land in the operand registers, but the decoder masks keep them out of every class and access decision [RULE_15]
endmodule
`default_nettype wire

// file: design/instr_field_decoder.sv
/*
 instr_field_decoder: combinational sort of a 14-bit word into group, class and operand fields.
 Assumes the caller registers whatever it needs to keep.
*/
`timescale 1ns/1ps
`default_nettype none
module instr_field_decoder (
   decode_if.producer dec
);
   // match helpers; only bits inside a mask take part, so don't-care bits never count [RULE_15]
   wire [13:0] w = dec.word;
   wire is_ctrl = ((w & instr_decode_pkg::M_CTRL) == instr_decode_pkg::V_CTRL);
   wire [1:0] grp_code = w[instr_decode_pkg::GRP_MSB:instr_decode_pkg::GRP_LSB];
   wire is_byte = (grp_code == instr_decode_pkg::GRP_BYTE_CODE) && !is_ctrl;
   wire is_bit = (grp_code == instr_decode_pkg::GRP_BIT_CODE);
   wire is_zero_acc = ((w & instr_decode_pkg::M_ZERO_ACC) == instr_decode_pkg::V_ZERO_ACC);
   wire is_call = ((w & instr_decode_pkg::M_LONG) == instr_decode_pkg::V_CALL)
      || ((w & instr_decode_pkg::M_FULL) == instr_decode_pkg::V_CALLACC);
   wire is_ret = ((w & instr_decode_pkg::M_FULL) == instr_decode_pkg::V_RET)
      || ((w & instr_decode_pkg::M_FULL) == instr_decode_pkg::V_RETINT)
      || ((w & instr_decode_pkg::M_RETLIT) == instr_decode_pkg::V_RETLIT);
   wire is_jump = ((w & instr_decode_pkg::M_LONG) == instr_decode_pkg::V_JUMP)
      || ((w & instr_decode_pkg::M_REL) == instr_decode_pkg::V_REL)
      || ((w & instr_decode_pkg::M_FULL) == instr_decode_pkg::V_JUMPACC);
   wire is_skip = ((w & instr_decode_pkg::M_SKIPF) == instr_decode_pkg::V_DEC_SKIP)
      || ((w & instr_decode_pkg::M_SKIPF) == instr_decode_pkg::V_INC_SKIP)
      || ((w & instr_decode_pkg::M_BTEST) == instr_decode_pkg::V_SKIP_ZERO)
      || ((w & instr_decode_pkg::M_BTEST) == instr_decode_pkg::V_SKIP_ONE);
   wire is_ptr_short = ((w & instr_decode_pkg::M_PTR_SHORT) == instr_decode_pkg::V_PTR_SHORT);
   wire is_ptr_index = ((w & instr_decode_pkg::M_PTR_INDEX) == instr_decode_pkg::V_PTR_INDEX);
   wire [6:0] faddr = w[instr_decode_pkg::F_MSB:instr_decode_pkg::F_LSB];
   wire names_file = (is_byte && !is_zero_acc) || is_bit;
   wire names_window = names_file && (faddr[6:1] == instr_decode_pkg::WINDOW_ADDR_HI);

   // three format groups; control words in the byte space belong to the literal group
   assign dec.group = is_byte ? instr_decode_pkg::grp_byte : // [RULE_02]
      (is_bit ? instr_decode_pkg::grp_bit : instr_decode_pkg::grp_literal);
   assign dec.kind = is_call ? instr_decode_pkg::cls_call : // [RULE_04]
      (is_ret ? instr_decode_pkg::cls_return : // [RULE_05]
      (is_jump ? instr_decode_pkg::cls_jump : // [RULE_06]
      (is_skip ? instr_decode_pkg::cls_skip : instr_decode_pkg::cls_plain)));
   // operand fields, all taken from the one word [RULE_01]
   assign dec.file_addr = faddr; // [RULE_11]
   assign dec.dest_file = is_bit ? 1'b1 : w[instr_decode_pkg::DEST_BIT]; // [RULE_10]
   assign dec.bit_pos = w[instr_decode_pkg::B_MSB:instr_decode_pkg::B_LSB]; // [RULE_12]
   assign dec.ptr_sel = is_ptr_short ? w[instr_decode_pkg::N_SHORT_BIT] : // [RULE_13]
      (is_ptr_index ? w[instr_decode_pkg::N_INDEX_BIT] : faddr[0]);
   assign dec.ptr_mode = w[instr_decode_pkg::MM_MSB:instr_decode_pkg::MM_LSB]; // [RULE_14]
   assign dec.file_op = names_file; // [RULE_09]
   // bit tests only read; clear-accumulator writes without naming a file
   assign dec.result_write = is_byte || (is_bit && !w[instr_decode_pkg::BIT_TEST_BIT]);
   assign dec.indirect = names_window || is_ptr_short || is_ptr_index;
endmodule
`default_nettype wire

// file: design/instr_phase_counter.sv
/*
 instr_phase_counter: divides the oscillator clock into instruction cycles.
 Assumes clk_i is the oscillator clock itself.
*/
`timescale 1ns/1ps
`default_nettype none
module instr_phase_counter (
   input wire logic clk_i,
   input wire logic rst_n_i,
   output logic [1:0] phase_o,
   output logic cycle_end_o
);
   logic [1:0] phase;

   // wraps after the last phase, so every instruction cycle is four clocks
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || phase == instr_decode_pkg::PHASE_LAST) begin
         phase <= instr_decode_pkg::PHASE_FIRST; // [RULE_08]
      end else begin
         phase <= phase + 2'h1;
      end
   end

   assign phase_o = phase;
   assign cycle_end_o = (phase == instr_decode_pkg::PHASE_LAST);
endmodule
`default_nettype wire
